// ---- rtl/fiad_alu.v ----
/*
  Combinational core ALU: three 64-bit operands, one result, seven flags.
  Assumes operands already selected; registering is done by the caller.
*/
`timescale 1ns/1ps
`include "fiad_defines.vh"

module fiad_alu
(
  input  wire [63:0] p,
  input  wire [63:0] q,
  input  wire [63:0] t,
  input  wire [3:0]  op,
  input  wire        flt,
  input  wire        negp,
  input  wire        negq,
  input  wire        negt,
  input  wire        negf,
  output wire [63:0] res,
  output wire [6:0]  flags
);

  // ----------------------------------------
  // Sign change
  // ----------------------------------------
  function [63:0] fiad_sgn;
    input [63:0] x;
    input        neg;
    input        isf;
    begin
      if (!neg)
        fiad_sgn = x;
      else if (isf)
        fiad_sgn = {~x[63], x[62:0]};
      else
        fiad_sgn = ~x + 64'h0000_0000_0000_0001;
    end
  endfunction

  reg  [63:0]  pa;
  reg  [63:0]  qa;
  reg  [63:0]  ta;
  reg  [63:0]  r;
  reg  [64:0]  s65;
  reg  [127:0] wide;
  reg          ovf;
  reg          inx;
  reg          inv;
  reg          gt;
  wire [63:0]  rf;

  // ----------------------------------------
  // Operation
  // ----------------------------------------
  always @*
  begin
    pa   = fiad_sgn(p, negp, flt);
    qa   = fiad_sgn(q, negq, flt);
    ta   = fiad_sgn(t, negt, flt);
    s65  = 65'h0;
    wide = 128'h0;
    ovf  = 1'b0;
    inx  = 1'b0;
    inv  = 1'b0;
    gt   = 1'b0;
    case (op)
      4'h0: r = pa;
      4'h1:
      begin
        s65 = {pa[63], pa} + {qa[63], qa};
        r   = s65[63:0];
        ovf = s65[64] ^ s65[63];
      end
      4'h2:
      begin
        s65 = {pa[63], pa} - {qa[63], qa};
        r   = s65[63:0];
        ovf = s65[64] ^ s65[63];
      end
      4'h3:
      begin
        wide = {64'h0, pa} * {64'h0, qa};
        r    = wide[63:0];
        inx  = |wide[127:64];
      end
      4'h4:
      begin
        wide = ({64'h0, pa} * {64'h0, qa}) + {64'h0, ta};
        r    = wide[63:0];
        inx  = |wide[127:64];
      end
      4'h5: r = pa & qa;
      4'h6: r = pa | qa;
      4'h7: r = pa ^ qa;
      4'h8: r = ~pa;
      4'h9:
      begin
        gt = $signed(pa) > $signed(qa);
        r  = {63'h0, gt};
      end
      4'ha:
      begin
        wide = {pa, qa} >> ta[5:0];
        r    = wide[63:0];
      end
      4'hb: r = pa << qa[5:0];
      default:
      begin
        r   = 64'h0;
        inv = 1'b1;
      end
    endcase
  end

  assign rf    = fiad_sgn(r, negf, flt);
  assign res   = rf;
  // Flags: gt, zero, inexact, underflow, overflow, reserved, invalid
  assign flags = {gt, ~|rf, inx,
                  flt & ~|rf[62:52] & |rf[51:0], ovf,
                  flt & (&pa[62:52] | &qa[62:52]), inv};

endmodule // fiad_alu

// ---- rtl/fiad_datapath.v ----
/*
  Datapath and exception status of the float/integer accelerator:
  holding and input registers, operand selectors, scratch file, ALU stages,
  flag and status registers, output multiplexer, checker compare.
  Assumes all inputs synchronous to clock; mode bits driven as plain ports.
*/
`timescale 1ns/1ps
`include "fiad_defines.vh"

module fiad_datapath
#(
  parameter [3:0] FLOW_CYCLES = `FIAD_FLOW_CYCLES
)
(
  input  wire        clock,
  input  wire        rst,
  input  wire        txn_req,
  input  wire        bus_valid,
  input  wire        txn_read,
  input  wire [2:0]  txn_type,
  input  wire        txn_start,
  input  wire        txn_suppress,
  input  wire [31:0] r_bus,
  input  wire [31:0] s_bus,
  input  wire [31:0] i_bus,
  input  wire        pipelined_alu_select,
  input  wire        alert_output_enable,
  input  wire        halt_on_error_enable,
  input  wire        zero_result_mask,
  input  wire        inexact_mask,
  input  wire        underflow_mask,
  input  wire        overflow_mask,
  input  wire        reserved_op_mask,
  input  wire        invalid_op_mask,
  input  wire        checker_mode,
  input  wire [31:0] peer_f_bus,
  input  wire [2:0]  peer_ctrl_n,
  output wire [31:0] f_bus,
  output wire        data_accept_n,
  output wire        data_ready_n,
  output wire        data_error_n,
  output wire        exception_alert_n,
  output wire        compare_mismatch
);

  // ----------------------------------------
  // Operand selection
  // ----------------------------------------
  function [63:0] fiad_opnd;
    input [3:0]  src;
    input [63:0] rv;
    input [63:0] sv;
    input [63:0] fv;
    input        fprec;
    input        inprec;
    input        isf;
    begin
      if (src[3])
        fiad_opnd = fprec ? fv : {32'h0, fv[31:0]};
      else
        case (src[2:0])
          3'h0: fiad_opnd = inprec ? rv : {32'h0, rv[31:0]};
          3'h1: fiad_opnd = inprec ? sv : {32'h0, sv[31:0]};
          3'h2: fiad_opnd = 64'h0;
          3'h3: fiad_opnd = isf ? `FIAD_K_ONE_F  : 64'h0000_0000_0000_0001;
          3'h4: fiad_opnd = isf ? `FIAD_K_TWO_F  : 64'h0000_0000_0000_0002;
          3'h5: fiad_opnd = isf ? `FIAD_K_HALF_F : 64'h0000_0000_0000_0020;
          3'h6: fiad_opnd = isf ? `FIAD_K_MONE_F : 64'hffff_ffff_ffff_ffff;
          default: fiad_opnd = isf ? `FIAD_K_ONE_F : 64'h0000_0000_0000_0040;
        endcase
    end
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  reg  [63:0] rtemp_q;
  reg  [63:0] stemp_q;
  reg  [31:0] itemp_q;
  reg         rtv_q;
  reg         stv_q;
  reg         itv_q;
  reg         pend_q;
  reg  [63:0] r_q;
  reg  [63:0] s_q;
  reg  [31:0] ins_q;
  reg         exv_q;
  reg  [3:0]  cnt_q;
  reg  [63:0] p1_q;
  reg  [6:0]  p1f_q;
  reg  [31:0] p1i_q;
  reg         p1v_q;
  reg  [63:0] p2_q;
  reg  [6:0]  p2f_q;
  reg  [31:0] p2i_q;
  reg         p2v_q;
  reg  [63:0] res_q;
  reg  [6:0]  flag_q;
  reg  [5:0]  sticky_q;
  reg  [7:0]  prec_q;
  reg  [31:0] f_q;
  reg         rdy_q;
  reg         err_q;
  reg         mis_q;
  reg  [31:0] f_d;
  wire [63:0] rf_q [0:7];

  // ----------------------------------------
  // Transaction decode
  // ----------------------------------------
  wire txn     = txn_req & bus_valid;
  wire wr      = txn & ~txn_read;
  wire rd      = txn & txn_read;
  wire wr_opnd = wr & (txn_type <= `FIAD_TW_INS);
  wire take    = wr_opnd & ~pend_q;
  wire wr_stat = wr & (txn_type == `FIAD_TW_STAT);

  // Operand writes wait while an operation is pending in the holding regs
  assign data_accept_n = ~(wr & (~wr_opnd | ~pend_q));

  // ----------------------------------------
  // Exception summary
  // ----------------------------------------
  wire [5:0] mask = {zero_result_mask, inexact_mask, underflow_mask,
                     overflow_mask, reserved_op_mask, invalid_op_mask};
  wire [5:0] unm  = sticky_q & ~mask;
  wire       exs  = |unm;
  wire       halt = halt_on_error_enable & exs;

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  wire p1_two   = p1i_q[`FIAD_I_TWO];
  // One-stage op behind a two-stage op waits so commits never collide
  wire p1_hold  = p1v_q & ~p1_two & p2v_q;
  wire p1_take  = ~p1v_q | ~p1_hold;
  wire pipe_mt  = ~p1v_q & ~p2v_q;
  wire ex_leave = exv_q & (pipelined_alu_select ? p1_take :
                           ((cnt_q == 4'h0) & pipe_mt));
  wire go       = pend_q & ~halt & (~exv_q | ex_leave) &
                  (pipelined_alu_select | pipe_mt);
  wire p1_load  = ex_leave & pipelined_alu_select;
  wire c2       = p2v_q;
  wire c1       = p1v_q & ~p1_two & ~p2v_q;
  wire cf       = ex_leave & ~pipelined_alu_select;
  wire commit   = c2 | c1 | cf;

  // ----------------------------------------
  // Operand selectors and ALU
  // ----------------------------------------
  wire [3:0]  srcp = ins_q[`FIAD_I_SRCP];
  wire [3:0]  srcq = ins_q[`FIAD_I_SRCQ];
  wire [3:0]  srct = ins_q[`FIAD_I_SRCT];
  wire        flt  = ins_q[`FIAD_I_FLT];
  wire        inp  = ins_q[`FIAD_I_INPREC];
  wire [63:0] opp  = fiad_opnd(srcp, r_q, s_q, rf_q[srcp[2:0]],
                               prec_q[srcp[2:0]], inp, flt);
  wire [63:0] opq  = fiad_opnd(srcq, r_q, s_q, rf_q[srcq[2:0]],
                               prec_q[srcq[2:0]], inp, flt);
  wire [63:0] opt  = fiad_opnd(srct, r_q, s_q, rf_q[srct[2:0]],
                               prec_q[srct[2:0]], inp, flt);
  wire [63:0] alu_res;
  wire [6:0]  alu_flg;

  fiad_alu fiad_alu_i
  (
    .p     (opp),
    .q     (opq),
    .t     (opt),
    .op    (ins_q[`FIAD_I_OP]),
    .flt   (flt),
    .negp  (ins_q[`FIAD_I_NEGP]),
    .negq  (ins_q[`FIAD_I_NEGQ]),
    .negt  (ins_q[`FIAD_I_NEGT]),
    .negf  (ins_q[`FIAD_I_NEGF]),
    .res   (alu_res),
    .flags (alu_flg)
  );

  // Commit source: oldest stage first
  wire [63:0] cres = c2 ? p2_q  : (c1 ? p1_q  : alu_res);
  wire [6:0]  cflg = c2 ? p2f_q : (c1 ? p1f_q : alu_flg);
  wire [31:0] cins = c2 ? p2i_q : (c1 ? p1i_q : ins_q);
  wire        rfwe = commit & cins[`FIAD_I_RFWE];
  wire [2:0]  dst  = cins[`FIAD_I_DST];

  // ----------------------------------------
  // Holding registers
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (rst)
    begin
      rtemp_q <= `FIAD_RST_W64;
      stemp_q <= `FIAD_RST_W64;
      itemp_q <= `FIAD_RST_W32;
      rtv_q   <= 1'b0;
      stv_q   <= 1'b0;
      itv_q   <= 1'b0;
      pend_q  <= 1'b0;
    end
    else
    begin
      if (take)
        case (txn_type)
          `FIAD_TW_RDBL:
          begin
            rtemp_q <= {r_bus, s_bus};
            rtv_q   <= 1'b1;
          end
          `FIAD_TW_SDBL:
          begin
            stemp_q <= {r_bus, s_bus};
            stv_q   <= 1'b1;
          end
          `FIAD_TW_RS:
          begin
            rtemp_q <= {32'h0, r_bus};
            stemp_q <= {32'h0, s_bus};
            rtv_q   <= 1'b1;
            stv_q   <= 1'b1;
          end
          default:
          begin
            itemp_q <= i_bus;
            itv_q   <= 1'b1;
          end
        endcase
      else if (go)
      begin
        rtv_q <= 1'b0;
        stv_q <= 1'b0;
        itv_q <= 1'b0;
      end
      if (take & txn_start)
        pend_q <= 1'b1;
      else if (go)
        pend_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Input, instruction and stage registers
  // ----------------------------------------
  always @(posedge clock)
  begin
    if (rst)
    begin
      r_q   <= `FIAD_RST_W64;
      s_q   <= `FIAD_RST_W64;
      ins_q <= `FIAD_RST_W32;
      exv_q <= 1'b0;
      cnt_q <= 4'h0;
      p1_q  <= `FIAD_RST_W64;
      p1f_q <= 7'h0;
      p1i_q <= `FIAD_RST_W32;
      p1v_q <= 1'b0;
      p2_q  <= `FIAD_RST_W64;
      p2f_q <= 7'h0;
      p2i_q <= `FIAD_RST_W32;
      p2v_q <= 1'b0;
    end
    else
    begin
      if (go)
      begin
        if (rtv_q)
          r_q <= rtemp_q;
        if (stv_q)
          s_q <= stemp_q;
        if (itv_q)
          ins_q <= itemp_q;
        exv_q <= 1'b1;
        cnt_q <= FLOW_CYCLES - 4'h1;
      end
      else
      begin
        if (ex_leave)
          exv_q <= 1'b0;
        if (exv_q && cnt_q != 4'h0)
          cnt_q <= cnt_q - 4'h1;
      end
      if (p1_load)
      begin
        p1_q  <= alu_res;
        p1f_q <= alu_flg;
        p1i_q <= ins_q;
        p1v_q <= 1'b1;
      end
      else if (p1_take)
        p1v_q <= 1'b0;
      p2v_q <= p1v_q & p1_two;
      if (p1v_q & p1_two)
      begin
        p2_q  <= p1_q;
        p2f_q <= p1f_q;
        p2i_q <= p1i_q;
      end
    end
  end

  // ----------------------------------------
  // Scratch file
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1)
    begin : g_rf
      reg [63:0] ent_q;
      always @(posedge clock)
      begin
        if (rst)
          ent_q <= `FIAD_RST_W64;
        else if (rfwe && dst == gi)
          ent_q <= cres;
      end
      assign rf_q[gi] = ent_q;
    end
  endgenerate

  // ----------------------------------------
  // Result, flag, status registers
  // ----------------------------------------
  wire [5:0] clr     = wr_stat ? r_bus[5:0] : 6'h0;
  wire [5:0] exc_in  = commit ? cflg[5:0] : 6'h0;
  // Set wins over a clear landing in the same cycle
  wire [5:0] sticky_d = (sticky_q & ~clr) | exc_in;

  always @(posedge clock)
  begin
    if (rst)
    begin
      res_q    <= `FIAD_RST_W64;
      flag_q   <= 7'h0;
      sticky_q <= 6'h0;
      prec_q   <= 8'h0;
    end
    else
    begin
      sticky_q <= sticky_d;
      if (commit)
      begin
        res_q  <= cres;
        flag_q <= cflg;
      end
      if (rfwe)
        prec_q[dst] <= cins[`FIAD_I_FPREC];
    end
  end

  wire busy = exv_q | p1v_q | p2v_q;
  wire [31:0] status_w = {19'h0, halt, busy, pend_q, itv_q, stv_q, rtv_q,
                          exs, sticky_q};

  // ----------------------------------------
  // Output multiplexer
  // ----------------------------------------
  always @*
  begin
    case (txn_type)
      `FIAD_TR_FLO:  f_d = res_q[31:0];
      `FIAD_TR_FHI:  f_d = res_q[63:32];
      `FIAD_TR_FLAG: f_d = {25'h0, flag_q};
      `FIAD_TR_STAT: f_d = status_w;
      `FIAD_TR_INS:  f_d = ins_q;
      `FIAD_TR_PREC: f_d = {24'h0, prec_q};
      default:       f_d = `FIAD_RST_W32;
    endcase
  end

  always @(posedge clock)
  begin
    if (rst)
    begin
      f_q   <= `FIAD_RST_W32;
      rdy_q <= 1'b0;
      err_q <= 1'b0;
      mis_q <= 1'b0;
    end
    else
    begin
      if (rd)
        f_q <= f_d;
      rdy_q <= rd;
      err_q <= rd & ~txn_suppress & exs;
      // Compare against what this device would drive
      mis_q <= checker_mode &
               ({f_q, ~rdy_q, ~err_q, exception_alert_n} !=
                {peer_f_bus, peer_ctrl_n});
    end
  end

  assign f_bus             = f_q;
  assign data_ready_n      = ~rdy_q;
  assign data_error_n      = ~err_q;
  assign exception_alert_n = ~(alert_output_enable & exs);
  assign compare_mismatch  = mis_q;

endmodule // fiad_datapath

// ---- rtl/fiad_defines.vh ----
/*
  Constants for the float/integer accelerator datapath: instruction word
  fields, transaction codes, built-in constants, timing, reset values.
  Assumes inclusion by bare name from every design file of the block.
*/
`ifndef FIAD_DEFINES_VH
`define FIAD_DEFINES_VH

// ----------------------------------------
// Instruction word fields
// ----------------------------------------
`define FIAD_I_OP     3:0
`define FIAD_I_FLT    4
`define FIAD_I_NEGP   5
`define FIAD_I_NEGQ   6
`define FIAD_I_NEGT   7
`define FIAD_I_NEGF   8
`define FIAD_I_FPREC  9
`define FIAD_I_SRCP   13:10
`define FIAD_I_SRCQ   17:14
`define FIAD_I_SRCT   21:18
`define FIAD_I_DST    24:22
`define FIAD_I_RFWE   25
`define FIAD_I_TWO    26
`define FIAD_I_INPREC 27

// ----------------------------------------
// Transaction codes
// ----------------------------------------
`define FIAD_TW_RDBL 3'h0
`define FIAD_TW_SDBL 3'h1
`define FIAD_TW_RS   3'h2
`define FIAD_TW_INS  3'h3
`define FIAD_TW_STAT 3'h4
`define FIAD_TR_FLO  3'h0
`define FIAD_TR_FHI  3'h1
`define FIAD_TR_FLAG 3'h2
`define FIAD_TR_STAT 3'h3
`define FIAD_TR_INS  3'h4
`define FIAD_TR_PREC 3'h5

// ----------------------------------------
// Constants, timing, reset values
// ----------------------------------------
`define FIAD_K_ONE_F  64'h3ff0_0000_0000_0000
`define FIAD_K_TWO_F  64'h4000_0000_0000_0000
`define FIAD_K_HALF_F 64'h3fe0_0000_0000_0000
`define FIAD_K_MONE_F 64'hbff0_0000_0000_0000
`define FIAD_FLOW_CYCLES 4'h3
`define FIAD_RST_W64  64'h0000_0000_0000_0000
`define FIAD_RST_W32  32'h0000_0000

`endif

// ---- tb/fiad_datapath_sva.sv ----
/*
  Checker for fiad_datapath port timing.
  Assumes the bind below and one clock domain.
*/
`timescale 1ns/1ps
module fiad_datapath_sva
(
  input wire        clock,
  input wire        rst,
  input wire        txn_req,
  input wire        bus_valid,
  input wire        txn_read,
  input wire [2:0]  txn_type,
  input wire        txn_suppress,
  input wire        alert_output_enable,
  input wire [31:0] f_bus,
  input wire        data_accept_n,
  input wire        data_ready_n,
  input wire        data_error_n,
  input wire        exception_alert_n,
  input wire        compare_mismatch
);
  wire rd_txn = txn_req & bus_valid & txn_read;
  wire wr_txn = txn_req & bus_valid & ~txn_read;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_rst_quiet: assert property (disable iff (1'b0) rst |=> data_ready_n && data_error_n
    && exception_alert_n && !compare_mismatch) else $error("outputs busy after reset");
  a_read_ready: assert property (rd_txn |=> !data_ready_n) else $error("no ready");
  a_ready_cause: assert property (!data_ready_n |-> $past(rd_txn))
    else $error("ready without read");
  a_error_ready: assert property (!data_error_n |-> !data_ready_n)
    else $error("error without ready");
  a_error_supp: assert property (rd_txn && txn_suppress |=> data_error_n)
    else $error("error not suppressed");
  a_alert_gate: assert property (!alert_output_enable |-> exception_alert_n)
    else $error("alert while disabled");
  a_accept_cause: assert property (!data_accept_n |-> wr_txn)
    else $error("accept without write");
  a_status_take: assert property (wr_txn && txn_type == 3'h4 |-> !data_accept_n)
    else $error("status write refused");
  a_fbus_hold: assert property (!$past(rd_txn) |-> $stable(f_bus))
    else $error("f_bus moved without read");
endmodule // fiad_datapath_sva

bind fiad_datapath fiad_datapath_sva fiad_datapath_sva_i (.*);

// ---- tb/fiad_datapath_tb.sv ----
/*
  Self-checking bench for fiad_datapath.
  Assumes default FLOW_CYCLES and the host model.
*/
`timescale 1ns/1ps
module fiad_datapath_tb;
  reg         clock = 1'b0;
  reg         rst = 1'b1;
  reg         pl = 1'b0;
  reg         aen = 1'b0;
  reg         hen = 1'b0;
  reg  [5:0]  msk = 6'h00;
  reg         cm = 1'b0;
  reg  [31:0] pf = 32'h0000_0000;
  reg  [2:0]  pc = 3'h7;
  integer     err_count = 0;
  integer     checks_done = 0;
  integer     cyc = 0;
  reg  [31:0] d;
  wire        rq, bv, rw, st, sp, acc_n, rdy_n, er_n, al_n, mm, herr;
  wire [2:0]  ty;
  wire [31:0] rb, sb, ib, fb;
  always #20 clock = ~clock;
  fiad_host fiad_host_i (.clock(clock), .txn_req(rq), .bus_valid(bv), .txn_read(rw),
    .txn_type(ty), .txn_start(st), .txn_suppress(sp), .r_bus(rb), .s_bus(sb), .i_bus(ib),
    .f_bus(fb), .data_accept_n(acc_n), .data_ready_n(rdy_n), .host_err(herr));
  fiad_datapath fiad_datapath_i (.clock(clock), .rst(rst), .txn_req(rq), .bus_valid(bv),
    .txn_read(rw), .txn_type(ty), .txn_start(st), .txn_suppress(sp), .r_bus(rb),
    .s_bus(sb), .i_bus(ib), .pipelined_alu_select(pl), .alert_output_enable(aen),
    .halt_on_error_enable(hen), .zero_result_mask(msk[5]), .inexact_mask(msk[4]),
    .underflow_mask(msk[3]), .overflow_mask(msk[2]), .reserved_op_mask(msk[1]),
    .invalid_op_mask(msk[0]), .checker_mode(cm), .peer_f_bus(pf), .peer_ctrl_n(pc),
    .f_bus(fb), .data_accept_n(acc_n), .data_ready_n(rdy_n), .data_error_n(er_n),
    .exception_alert_n(al_n), .compare_mismatch(mm));
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e)
      begin
        err_count = err_count + 1;
        $display("CHECK FAILED %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  task op(input [63:0] r, input [63:0] s, input [31:0] ins);
    begin
      fiad_host_i.wr(3'h0, r[63:32], r[31:0], 32'h0000_0000, 1'b0);
      fiad_host_i.wr(3'h1, s[63:32], s[31:0], 32'h0000_0000, 1'b0);
      fiad_host_i.wr(3'h3, 32'h0000_0000, 32'h0000_0000, ins, 1'b1);
      repeat (8) @(negedge clock);
    end
  endtask
  task res(input [63:0] e);
    begin
      fiad_host_i.rd(3'h0, 1'b0, d);
      chk(d, e[31:0]);
      fiad_host_i.rd(3'h1, 1'b0, d);
      chk(d, e[63:32]);
    end
  endtask
  task t_reset;
    begin
      fiad_host_i.rd(3'h3, 1'b0, d);
      chk(d, 32'h0000_0000);
      fiad_host_i.rd(3'h5, 1'b0, d);
      chk(d, 32'h0000_0000);
    end
  endtask
  task t_pass;
    begin
      op(64'h1234_5678_9abc_def0, 64'h0, 32'h0800_0200);
      res(64'h1234_5678_9abc_def0);
    end
  endtask
  // Second op queued behind first; reads first result from scratch 1
  task t_queue;
    begin
      fiad_host_i.wr(3'h0, 32'h0000_0001, 32'hffff_ffff, 32'h0000_0000, 1'b0);
      fiad_host_i.wr(3'h1, 32'h0000_0000, 32'h0000_0001, 32'h0000_0000, 1'b0);
      fiad_host_i.wr(3'h3, 32'h0000_0000, 32'h0000_0000, 32'h0a40_4201, 1'b1);
      fiad_host_i.wr(3'h0, 32'h5555_5555, 32'h5555_5555, 32'h0000_0000, 1'b0);
      fiad_host_i.wr(3'h3, 32'h0000_0000, 32'h0000_0000, 32'h0800_2600, 1'b1);
      repeat (12) @(negedge clock);
      res(64'h0000_0002_0000_0000);
      fiad_host_i.rd(3'h5, 1'b0, d);
      chk(d, 32'h0000_0002);
    end
  endtask
  task t_pipe;
    begin
      @(negedge clock);
      pl = 1'b1;
      op(64'h0000_0001_ffff_ffff, 64'h1, 32'h0c00_4301);
      res(64'hffff_fffe_0000_0000);
      pl = 1'b0;
    end
  endtask
  task t_exc;
    begin
      @(negedge clock);
      aen = 1'b1;
      op(64'h0, 64'h0, 32'h0800_020f);
      fiad_host_i.rd(3'h3, 1'b0, d);
      chk({25'h0, d[6:0]}, 32'h0000_0061);
      chk({31'h0, er_n}, 32'h0000_0000);
      chk({31'h0, al_n}, 32'h0000_0000);
      fiad_host_i.rd(3'h2, 1'b1, d);
      chk({31'h0, d[0]}, 32'h0000_0001);
      // Halt keeps a queued op pending while the exception stands
      hen = 1'b1;
      fiad_host_i.wr(3'h3, 32'h0000_0000, 32'h0000_0000, 32'h0800_0200, 1'b1);
      fiad_host_i.rd(3'h3, 1'b0, d);
      chk({28'h0, d[12:9]}, 32'h0000_000b);
      hen = 1'b0;
      repeat (6) @(negedge clock);
      aen = 1'b0;
      #1;
      chk({31'h0, al_n}, 32'h0000_0001);
      msk = 6'h21;
      fiad_host_i.rd(3'h3, 1'b0, d);
      chk({25'h0, d[6:0]}, 32'h0000_0021);
      chk({31'h0, er_n}, 32'h0000_0001);
      fiad_host_i.wr(3'h4, 32'h0000_0021, 32'h0000_0000, 32'h0000_0000, 1'b0);
      fiad_host_i.rd(3'h3, 1'b0, d);
      chk({25'h0, d[6:0]}, 32'h0000_0000);
      msk = 6'h00;
    end
  endtask
  task t_cmp;
    begin
      fiad_host_i.rd(3'h6, 1'b0, d);
      cm = 1'b1;
      repeat (3) @(negedge clock);
      chk({31'h0, mm}, 32'h0000_0000);
      pf = 32'h0000_0001;
      repeat (3) @(negedge clock);
      chk({31'h0, mm}, 32'h0000_0001);
      cm = 1'b0;
    end
  endtask
  task summarize;
    begin
      if (herr !== 1'b0)
        err_count = err_count + 1;
      if (err_count == 0 && checks_done > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // Ceiling well above the 120 or so cycles needed
  always @(posedge clock)
  begin
    cyc = cyc + 1;
    if (cyc == 20000)
    begin
      err_count = err_count + 1;
      summarize;
    end
  end
  initial
  begin
    repeat (5) @(negedge clock);
    rst = 1'b0;
    t_reset;
    t_pass;
    t_queue;
    t_pipe;
    t_exc;
    t_cmp;
    summarize;
  end
endmodule // fiad_datapath_tb

// ---- tb/fiad_host.sv ----
/*
  Host model issuing transactions to the datapath.
  Assumes bench clock; drives at falling edges.
*/
`timescale 1ns/1ps
module fiad_host
(
  input  wire        clock,
  output reg         txn_req,
  output reg         bus_valid,
  output reg         txn_read,
  output reg  [2:0]  txn_type,
  output reg         txn_start,
  output reg         txn_suppress,
  output reg  [31:0] r_bus,
  output reg  [31:0] s_bus,
  output reg  [31:0] i_bus,
  input  wire [31:0] f_bus,
  input  wire        data_accept_n,
  input  wire        data_ready_n,
  output reg         host_err
);
  initial
  begin
    host_err = 1'b0;
    r_bus = 32'h0000_0000;
    s_bus = 32'h0000_0000;
    i_bus = 32'h0000_0000;
    idle;
  end
  // Released buses flip so stale data never looks valid
  task idle;
    begin
      {txn_req, bus_valid, txn_read, txn_type, txn_start, txn_suppress} = 8'h00;
      r_bus = ~r_bus;
      s_bus = ~s_bus;
      i_bus = ~i_bus;
    end
  endtask
  // Write held until accepted; bounded wait
  task wr(input [2:0] ty, input [31:0] r, input [31:0] s, input [31:0] i, input st);
    integer n;
    begin
      @(negedge clock);
      {txn_req, bus_valid, txn_read, txn_type, txn_start} = {3'h6, ty, st};
      r_bus = r;
      s_bus = s;
      i_bus = i;
      n = 0;
      #5;
      while (data_accept_n !== 1'b0 && n < 50)
      begin
        @(negedge clock);
        #5;
        n = n + 1;
      end
      if (n == 50)
        host_err = 1'b1;
      @(negedge clock);
      idle;
    end
  endtask
  task rd(input [2:0] ty, input sup, output [31:0] d);
    begin
      @(negedge clock);
      {txn_req, bus_valid, txn_read, txn_type, txn_start, txn_suppress} = {3'h7, ty, 1'b0, sup};
      @(negedge clock);
      if (data_ready_n !== 1'b0)
        host_err = 1'b1;
      d = f_bus;
      idle;
    end
  endtask
endmodule // fiad_host
